// >>> design/prc_cfg.svh
// Purpose: constants of the packet rate and configuration interpreter
// Assumes: byte-wide payloads, little-endian multi-byte fields
// Notes: definitions only
`ifndef PRC_CFG_SVH
`define PRC_CFG_SVH

// ----------------------------------------------------------------
// packet identifiers and lengths
// ----------------------------------------------------------------
`define PRC_ID_GIM 8'h48
`define PRC_ID_AUTO 8'h49
`define PRC_ID_TMR 8'hB4
`define PRC_ID_PER 8'hB5
`define PRC_ID_BAUD 8'hB6
`define PRC_ID_ALN 8'hB9
`define PRC_LEN_GIM 8'h08
`define PRC_LEN_AUTO 8'h18
`define PRC_LEN_TMR 8'h04
`define PRC_LEN_BAUD 8'h11
`define PRC_LEN_ALN 8'h49
`define PRC_LEN_PER_HDR 8'h02
`define PRC_LEN_PER_ENT 8'h05
`define PRC_MAX_LEN 73
`define PRC_MAX_ENT 14

// ----------------------------------------------------------------
// field offsets
// ----------------------------------------------------------------
`define PRC_OFS_PERM 0
`define PRC_OFS_UTC 1
`define PRC_OFS_TPER 2
`define PRC_OFS_CLR 1
`define PRC_OFS_ENT 2
`define PRC_OFS_BPRI 1
`define PRC_OFS_BGPIO 5
`define PRC_OFS_BAUX 9
`define PRC_GIM_DATA_LEN 4
`define PRC_AUTO_DATA_LEN 20

// ----------------------------------------------------------------
// limits
// ----------------------------------------------------------------
`define PRC_TPER_MIN 16'h03E8
`define PRC_US_PER_S 32'h000F4240
`define PRC_BAUD_MIN 32'h00000960
`define PRC_BAUD_PRI_MAX 32'h00989680
`define PRC_BAUD_GPIO_MAX 32'h0003D090
`define PRC_BAUD_AUX_MAX 32'h001E8480

// ----------------------------------------------------------------
// clock and reset values
// ----------------------------------------------------------------
`define PRC_CLK_HZ 32'h00989680
`define PRC_CYC_PER_US (`PRC_CLK_HZ / `PRC_US_PER_S)
`define PRC_DEF_TPER 16'h03E8
`define PRC_DEF_BAUD 32'h0001C200
`define PRC_FP_ONE 32'h3F800000

`endif

// >>> design/prc_pkg.sv
// Purpose: shared types of the packet rate and configuration interpreter
// Assumes: prc_cfg.svh holds the numbers
// Notes: none
`include "prc_cfg.svh"
package prc_pkg;
	typedef enum logic [1:0] {
		PRC_RX_BOOT = 2'b00,
		PRC_RX_IDLE = 2'b01,
		PRC_RX_BODY = 2'b11,
		PRC_RX_COMMIT = 2'b10
	} prc_rx_st_t;

	typedef struct packed {
		logic first;
		logic last;
		logic [7:0] data;
	} prc_word_t;

	typedef logic [`PRC_MAX_LEN-1:0][7:0] prc_img_t;
endpackage

// >>> design/prc_stream_if.sv
// Purpose: valid/ready word carrier between the interpreter and its buffer
// Assumes: one clock
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface prc_stream_if #(parameter int W = 10);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> design/prc_skid_buf.sv
// Purpose: two-entry buffer on the outgoing byte stream
// Assumes: one clock, asynchronous active-low reset
// Notes: full/empty are exact, so a stalled sink pushes back on the source
`timescale 1ns/1ps
`default_nettype none
module prc_skid_buf #(parameter int W = 10) (
	input wire logic ref_clk_in,     // system clock
	input wire logic reset_n_in,     // asynchronous reset, active low
	prc_stream_if.snk in_if,         // filling side
	prc_stream_if.src out_if         // draining side
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic wp;
		logic rp;
		logic [1:0] cnt;
	} prc_buf_t;

	prc_buf_t s_reg;
	prc_buf_t s_next;
	logic push;
	logic pop;

	assign in_if.ready = (s_reg.cnt != 2'h2);
	assign out_if.valid = (s_reg.cnt != 2'h0);
	assign out_if.data = s_reg.mem[s_reg.rp];
	assign push = in_if.valid && in_if.ready;
	assign pop = out_if.valid && out_if.ready;

	always_comb begin
		s_next = s_reg;
		if (push) begin
			s_next.mem[s_reg.wp] = in_if.data;
			s_next.wp = ~s_reg.wp;
		end
		if (pop) begin
			s_next.rp = ~s_reg.rp;
		end
		s_next.cnt = s_reg.cnt + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule
`default_nettype wire

// >>> design/prc_interpreter.sv
// Purpose: configuration packet interpreter and periodic output scheduler
// Assumes: framing and checksum are handled outside; one byte per beat
// Notes: por_n_in clears only the permanent copy, reset_n_in the rest
`timescale 1ns/1ps
`default_nettype none
`include "prc_cfg.svh"
module prc_interpreter import prc_pkg::*; #(
	parameter int NS = 8,                    // period table slots
	parameter logic [31:0] DEF_BAUD = `PRC_DEF_BAUD
) (
	input wire logic ref_clk_in,             // 10 MHz system clock
	input wire logic reset_n_in,             // system reset, active low
	input wire logic por_n_in,               // power-on clear, active low
	input wire logic rx_valid_in,            // packet byte valid
	output logic rx_ready_out,               // packet byte accepted
	input wire logic [7:0] rx_data_in,       // packet byte
	input wire logic rx_first_in,            // first byte, id valid
	input wire logic rx_last_in,             // last byte of packet
	input wire logic [7:0] rx_id_in,         // packet id
	input wire logic rd_req_in,              // read request
	output logic rd_ready_out,               // read request accepted
	input wire logic [7:0] rd_id_in,         // id to read back
	input wire logic gim_valid_in,           // gimbal data arrived
	input wire logic [31:0] gim_angle_in,    // gimbal angle float
	input wire logic auto_valid_in,          // automotive data arrived
	input wire logic [31:0] auto_odo_in,     // odometer distance float
	input wire logic [31:0] auto_slip_in,    // slip angle float
	input wire logic [31:0] auto_velx_in,    // velocity x float
	input wire logic [31:0] auto_vely_in,    // velocity y float
	input wire logic [31:0] auto_dev_in,     // distance deviation float
	input wire logic utc_pps_in,             // utc second pulse pin
	output logic tx_valid_out,               // output byte valid
	input wire logic tx_ready_in,            // output byte taken
	output logic [7:0] tx_data_out,          // output byte
	output logic tx_first_out,               // id byte of a frame
	output logic tx_last_out,                // last byte of a frame
	output logic utc_sync_out,               // utc sync enabled
	output logic [15:0] timer_period_out,    // timer period, us
	output logic [31:0] baud_pri_out,        // primary port rate
	output logic [31:0] baud_gpio_out,       // gpio pin rate
	output logic [31:0] baud_aux_out,        // auxiliary port rate
	output logic [575:0] align_out,          // matrix and offsets
	output logic tick_out,                   // master timer tick
	output logic reject_out                  // packet dropped
);
	localparam int CW = $clog2(NS + 1);

	typedef struct packed {
		logic [3:0][7:0] tmr;
		logic [16:0][7:0] baud;
		logic [72:0][7:0] aln;
		logic [7:0] per_perm;
		logic [CW-1:0] n;
		logic [NS-1:0][7:0] sid;
		logic [NS-1:0][31:0] sper;
	} prc_set_t;

	typedef struct packed {
		prc_rx_st_t rx;
		logic [7:0] rx_id;
		logic [7:0] rx_cnt;
		prc_img_t stage;
		prc_set_t cfg;
		logic [23:0] tick_cnt;
		logic tick;
		logic reject;
		logic [NS-1:0][31:0] slot_cnt;
		logic [31:0] gim;
		logic [4:0][31:0] auto_d;
		logic pend_gim;
		logic pend_auto;
		logic rd_pend;
		logic [7:0] rd_id;
		logic busy;
		logic [7:0] tx_id;
		logic [7:0] tx_len;
		logic [7:0] tx_idx;
		logic pps_s1;
		logic pps_s2;
		logic pps_s3;
	} prc_state_t;

	prc_state_t s_reg;
	prc_state_t s_next;
	prc_set_t p_reg;
	prc_set_t p_next;
	prc_word_t tx_word;

	prc_stream_if #(.W(10)) up_if ();
	prc_stream_if #(.W(10)) dn_if ();

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] get32(prc_img_t a, int o);
		get32 = {a[o + 3], a[o + 2], a[o + 1], a[o]};
	endfunction

	function automatic logic has_slot(prc_set_t c, logic [7:0] id);
		has_slot = 1'b0;
		for (int j = 0; j < NS; j++) begin
			if (j < c.n && c.sid[j] == id) begin
				has_slot = 1'b1;
			end
		end
	endfunction

	function automatic logic [7:0] len_of(prc_set_t c, logic [7:0] id);
		case (id)
			`PRC_ID_TMR: len_of = `PRC_LEN_TMR;
			`PRC_ID_PER: len_of = 8'(`PRC_LEN_PER_HDR + 8'(c.n) * `PRC_LEN_PER_ENT);
			`PRC_ID_BAUD: len_of = `PRC_LEN_BAUD;
			`PRC_ID_ALN: len_of = `PRC_LEN_ALN;
			`PRC_ID_GIM: len_of = `PRC_LEN_GIM;
			`PRC_ID_AUTO: len_of = `PRC_LEN_AUTO;
			default: len_of = 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] byte_at(prc_state_t s, logic [7:0] i);
		logic [7:0] e;
		logic [7:0] r;
		logic [31:0] w;
		e = 8'((i - 8'h02) / `PRC_LEN_PER_ENT);
		r = 8'((i - 8'h02) % `PRC_LEN_PER_ENT);
		w = s.cfg.sper[e[$clog2(NS)-1:0]];
		byte_at = 8'h00;
		case (s.tx_id)
			`PRC_ID_TMR: byte_at = s.cfg.tmr[i[1:0]];
			`PRC_ID_BAUD: byte_at = s.cfg.baud[i];
			`PRC_ID_ALN: byte_at = s.cfg.aln[i];
			`PRC_ID_PER: begin
				if (i == `PRC_OFS_PERM) begin
					byte_at = s.cfg.per_perm;
				end else if (i >= `PRC_OFS_ENT && r == 8'h00) begin
					byte_at = s.cfg.sid[e[$clog2(NS)-1:0]];
				end else if (i >= `PRC_OFS_ENT) begin
					byte_at = w[8 * (r - 8'h01) +: 8];
				end
			end
			`PRC_ID_GIM: begin
				if (i < `PRC_GIM_DATA_LEN) begin
					byte_at = s.gim[8 * i[1:0] +: 8];
				end
			end
			`PRC_ID_AUTO: begin
				if (i < `PRC_AUTO_DATA_LEN) begin
					byte_at = s.auto_d[i / 4][8 * i[1:0] +: 8];
				end
			end
			default: byte_at = 8'h00;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// outgoing byte stream through the two-entry buffer
	// ----------------------------------------------------------------
	always_comb begin
		tx_word.first = (s_reg.tx_idx == 8'h00);
		tx_word.last = (s_reg.tx_idx == s_reg.tx_len + 8'h01);
		if (s_reg.tx_idx == 8'h00) begin
			tx_word.data = s_reg.tx_id;
		end else if (s_reg.tx_idx == 8'h01) begin
			tx_word.data = s_reg.tx_len;
		end else begin
			tx_word.data = byte_at(s_reg, s_reg.tx_idx - 8'h02);
		end
	end

	assign up_if.valid = s_reg.busy;
	assign up_if.data = tx_word;
	assign dn_if.ready = tx_ready_in;
	assign tx_valid_out = dn_if.valid;
	assign {tx_first_out, tx_last_out, tx_data_out} = dn_if.data;

	prc_skid_buf #(.W(10)) u_buf (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.in_if(up_if),
		.out_if(dn_if)
	);

	// ----------------------------------------------------------------
	// handshakes and settings outputs
	// ----------------------------------------------------------------
	assign rx_ready_out = (s_reg.rx == PRC_RX_IDLE) || (s_reg.rx == PRC_RX_BODY);
	assign rd_ready_out = !s_reg.rd_pend;
	assign utc_sync_out = s_reg.cfg.tmr[`PRC_OFS_UTC][0];
	assign timer_period_out = {s_reg.cfg.tmr[3], s_reg.cfg.tmr[2]};
	assign baud_pri_out = get32(prc_img_t'(s_reg.cfg.baud), `PRC_OFS_BPRI);
	assign baud_gpio_out = get32(prc_img_t'(s_reg.cfg.baud), `PRC_OFS_BGPIO);
	assign baud_aux_out = get32(prc_img_t'(s_reg.cfg.baud), `PRC_OFS_BAUX);
	assign align_out = s_reg.cfg.aln[72:1];
	assign tick_out = s_reg.tick;
	assign reject_out = s_reg.reject;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [15:0] per;
		logic [31:0] ep;
		logic [7:0] eid;
		logic [7:0] len;
		logic [7:0] ents;
		logic [CW-1:0] cw;
		logic found;
		logic ok;
		logic perm;
		per = {s_reg.stage[3], s_reg.stage[2]};
		ep = 32'h0;
		eid = 8'h00;
		len = s_reg.rx_cnt;
		ents = 8'((len - `PRC_LEN_PER_HDR) / `PRC_LEN_PER_ENT);
		cw = '0;
		found = 1'b0;
		ok = 1'b0;
		perm = (s_reg.stage[`PRC_OFS_PERM] == 8'h01);
		s_next = s_reg;
		p_next = p_reg;
		s_next.tick = 1'b0;
		s_next.reject = 1'b0;
		s_next.pps_s1 = utc_pps_in;
		s_next.pps_s2 = s_reg.pps_s1;
		s_next.pps_s3 = s_reg.pps_s2;

		case (s_reg.rx)
			PRC_RX_BOOT: begin
				s_next.cfg = p_reg;
				s_next.rx = PRC_RX_IDLE;
			end
			PRC_RX_IDLE: begin
				if (rx_valid_in && rx_first_in) begin
					s_next.rx_id = rx_id_in;
					s_next.rx_cnt = 8'h01;
					s_next.stage[0] = rx_data_in;
					s_next.rx = rx_last_in ? PRC_RX_COMMIT : PRC_RX_BODY;
				end
			end
			PRC_RX_BODY: begin
				if (rx_valid_in) begin
					if (s_reg.rx_cnt < `PRC_MAX_LEN) begin
						s_next.stage[s_reg.rx_cnt] = rx_data_in;
					end
					if (s_reg.rx_cnt != 8'hFF) begin
						s_next.rx_cnt = s_reg.rx_cnt + 8'h01;
					end
					if (rx_last_in) begin
						s_next.rx = PRC_RX_COMMIT;
					end
				end
			end
			PRC_RX_COMMIT: begin
				s_next.rx = PRC_RX_IDLE;
				case (s_reg.rx_id)
					`PRC_ID_TMR: begin
						ok = (len == `PRC_LEN_TMR)
							&& (per >= `PRC_TPER_MIN)
							&& (s_reg.stage[`PRC_OFS_UTC] <= 8'h01)
							&& (s_reg.stage[`PRC_OFS_UTC] == 8'h00
							|| (`PRC_US_PER_S % {16'h0, per}) == 32'h0);
						if (ok) begin
							s_next.cfg.tmr = s_reg.stage[3:0];
							if (perm) begin
								p_next.tmr = s_reg.stage[3:0];
							end
						end
					end
					`PRC_ID_PER: begin
						ok = (len >= `PRC_LEN_PER_HDR)
							&& (len <= `PRC_MAX_LEN)
							&& ((len - `PRC_LEN_PER_HDR) % `PRC_LEN_PER_ENT == 0);
						if (ok) begin
							s_next.cfg.per_perm = s_reg.stage[`PRC_OFS_PERM];
							cw = (s_reg.stage[`PRC_OFS_CLR] == 8'h01)
								? '0 : s_reg.cfg.n;
							for (int e = 0; e < `PRC_MAX_ENT; e++) begin
								if (e < ents) begin
									eid = s_reg.stage[`PRC_OFS_ENT + 5 * e];
									ep = get32(s_reg.stage, `PRC_OFS_ENT + 5 * e + 1);
									found = 1'b0;
									for (int j = 0; j < NS; j++) begin
										if (j < cw && s_next.cfg.sid[j] == eid) begin
											s_next.cfg.sper[j] = ep;
											s_next.slot_cnt[j] = 32'h0;
											found = 1'b1;
										end
									end
									// table overflow drops the extra entries
									if (!found && cw < NS) begin
										s_next.cfg.sid[cw] = eid;
										s_next.cfg.sper[cw] = ep;
										s_next.slot_cnt[cw] = 32'h0;
										cw = CW'(cw + 1'b1);
									end
								end
							end
							s_next.cfg.n = cw;
							if (perm) begin
								p_next.per_perm = s_reg.stage[`PRC_OFS_PERM];
								p_next.n = cw;
								p_next.sid = s_next.cfg.sid;
								p_next.sper = s_next.cfg.sper;
							end
						end
					end
					`PRC_ID_BAUD: begin
						ok = (len == `PRC_LEN_BAUD);
						ep = get32(s_reg.stage, `PRC_OFS_BPRI);
						ok = ok && ep >= `PRC_BAUD_MIN && ep <= `PRC_BAUD_PRI_MAX;
						ep = get32(s_reg.stage, `PRC_OFS_BGPIO);
						ok = ok && ep >= `PRC_BAUD_MIN && ep <= `PRC_BAUD_GPIO_MAX;
						ep = get32(s_reg.stage, `PRC_OFS_BAUX);
						ok = ok && ep >= `PRC_BAUD_MIN && ep <= `PRC_BAUD_AUX_MAX;
						if (ok) begin
							s_next.cfg.baud = s_reg.stage[16:0];
							if (perm) begin
								p_next.baud = s_reg.stage[16:0];
							end
						end
					end
					`PRC_ID_ALN: begin
						ok = (len == `PRC_LEN_ALN);
						if (ok) begin
							s_next.cfg.aln = s_reg.stage[72:0];
							if (perm) begin
								p_next.aln = s_reg.stage[72:0];
							end
						end
					end
					default: ok = 1'b0;
				endcase
				s_next.reject = !ok;
			end
			default: s_next.rx = PRC_RX_IDLE;
		endcase

		// master timer; a utc second edge restarts its phase
		if (utc_sync_out && s_reg.pps_s2 && !s_reg.pps_s3) begin
			s_next.tick_cnt = 24'h0;
		end else if (s_reg.tick_cnt + 24'h1 >=
			24'(timer_period_out) * 24'(`PRC_CYC_PER_US)) begin
			s_next.tick_cnt = 24'h0;
			s_next.tick = 1'b1;
		end else begin
			s_next.tick_cnt = s_reg.tick_cnt + 24'h1;
		end

		// transmit start; clears come before sets so a new event wins
		if (s_reg.busy && up_if.ready) begin
			s_next.tx_idx = s_reg.tx_idx + 8'h01;
			if (tx_word.last) begin
				s_next.busy = 1'b0;
			end
		end else if (!s_reg.busy) begin
			s_next.tx_idx = 8'h00;
			if (s_reg.rd_pend) begin
				s_next.busy = 1'b1;
				s_next.tx_id = s_reg.rd_id;
				s_next.tx_len = len_of(s_reg.cfg, s_reg.rd_id);
				s_next.rd_pend = 1'b0;
			end else if (s_reg.pend_gim) begin
				s_next.busy = 1'b1;
				s_next.tx_id = `PRC_ID_GIM;
				s_next.tx_len = `PRC_LEN_GIM;
				s_next.pend_gim = 1'b0;
			end else if (s_reg.pend_auto) begin
				s_next.busy = 1'b1;
				s_next.tx_id = `PRC_ID_AUTO;
				s_next.tx_len = `PRC_LEN_AUTO;
				s_next.pend_auto = 1'b0;
			end
		end

		if (rd_req_in && !s_reg.rd_pend) begin
			if (rd_id_in == `PRC_ID_TMR || rd_id_in == `PRC_ID_PER
				|| rd_id_in == `PRC_ID_BAUD || rd_id_in == `PRC_ID_ALN) begin
				s_next.rd_pend = 1'b1;
				s_next.rd_id = rd_id_in;
			end
		end

		// used period slots with a nonzero period advance on each tick
		if (s_reg.tick) begin
			for (int j = 0; j < NS; j++) begin
				if (j < s_reg.cfg.n && s_reg.cfg.sper[j] != 32'h0) begin
					if (s_reg.slot_cnt[j] + 32'h1 >= s_reg.cfg.sper[j]) begin
						s_next.slot_cnt[j] = 32'h0;
						if (s_reg.cfg.sid[j] == `PRC_ID_GIM) begin
							s_next.pend_gim = 1'b1;
						end
						if (s_reg.cfg.sid[j] == `PRC_ID_AUTO) begin
							s_next.pend_auto = 1'b1;
						end
					end else begin
						s_next.slot_cnt[j] = s_reg.slot_cnt[j] + 32'h1;
					end
				end
			end
		end

		// new source data; a frame in flight may pick up fresh fields
		if (gim_valid_in) begin
			s_next.gim = gim_angle_in;
			if (!has_slot(s_reg.cfg, `PRC_ID_GIM)) begin
				s_next.pend_gim = 1'b1;
			end
		end
		if (auto_valid_in) begin
			s_next.auto_d = {auto_dev_in, auto_vely_in, auto_velx_in,
				auto_slip_in, auto_odo_in};
			if (!has_slot(s_reg.cfg, `PRC_ID_AUTO)) begin
				s_next.pend_auto = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// permanent copy survives system reset; only power-on clears it
	always_ff @(posedge ref_clk_in or negedge por_n_in) begin
		if (!por_n_in) begin
			p_reg <= '0;
			p_reg.tmr[3:2] <= `PRC_DEF_TPER;
			p_reg.baud[4:1] <= DEF_BAUD;
			p_reg.baud[8:5] <= DEF_BAUD;
			p_reg.baud[12:9] <= DEF_BAUD;
			p_reg.aln[4:1] <= `PRC_FP_ONE;
			p_reg.aln[20:17] <= `PRC_FP_ONE;
			p_reg.aln[36:33] <= `PRC_FP_ONE;
		end else begin
			p_reg <= p_next;
		end
	end
endmodule
`default_nettype wire

// >>> test/prc_host_sink.sv
// Purpose: host side taking the output byte stream
// Assumes: one clock
// Notes: stalls at random so the buffer fills
`timescale 1ns/1ps
`default_nettype none
module prc_host_sink (
	input wire logic ref_clk_in,       // clock
	input wire logic tx_valid_in,      // byte valid
	input wire logic [7:0] tx_data_in, // byte
	input wire logic tx_first_in,      // id byte
	input wire logic tx_last_in,       // last byte
	output logic tx_ready_out          // byte taken
);
	// ------
	// capture
	// ------
	logic [7:0] q[$];
	bit lst[$];
	int ft[$];
	int cyc = 0;
	initial tx_ready_out = 1'b0;
	always @(posedge ref_clk_in) begin
		cyc++;
		if (tx_valid_in && tx_ready_out) begin
			q.push_back(tx_data_in);
			lst.push_back(tx_last_in);
			if (tx_first_in && tx_data_in == 8'h48)
				ft.push_back(cyc);
		end
		tx_ready_out <= ($urandom % 4) != 0;
	end
endmodule
`default_nettype wire

// >>> test/prc_interpreter_chk.sv
// Purpose: port checker of the interpreter
// Assumes: one clock, reset_n_in asynchronous active low
// Notes: bound at the foot
`timescale 1ns/1ps
`default_nettype none
module prc_interpreter_chk (
	input wire logic ref_clk_in,             // clock
	input wire logic reset_n_in,             // reset
	input wire logic rx_valid_in,            // byte valid
	input wire logic rx_last_in,             // last byte
	input wire logic rx_ready_out,           // byte taken
	input wire logic tx_valid_out,           // out valid
	input wire logic tx_ready_in,            // out taken
	input wire logic [7:0] tx_data_out,      // out byte
	input wire logic tx_first_out,           // id byte
	input wire logic utc_sync_out,           // utc sync
	input wire logic [15:0] timer_period_out, // period
	input wire logic [31:0] baud_pri_out,    // primary
	input wire logic [31:0] baud_gpio_out,   // gpio
	input wire logic [31:0] baud_aux_out,    // auxiliary
	input wire logic tick_out,               // tick
	input wire logic reject_out              // dropped
);
	// ------
	// checks
	// ------
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);
	AST_REJ_ONE: assert property (reject_out |=> !reject_out)
		else $error("reject longer than a cycle");
	AST_REJ_KEEP: assert property (reject_out |-> $stable(timer_period_out)
		&& $stable(baud_pri_out) && $stable(utc_sync_out))
		else $error("setting changed on reject");
	AST_COMMIT: assert property (rx_valid_in && rx_ready_out && rx_last_in
		|=> !rx_ready_out ##1 rx_ready_out) else $error("commit slot wrong");
	AST_TX_HOLD: assert property (tx_valid_out && !tx_ready_in
		|=> tx_valid_out && $stable(tx_data_out) && $stable(tx_first_out))
		else $error("stalled byte not held");
	AST_TX_ID: assert property (tx_valid_out && tx_first_out |-> tx_data_out
		inside {8'h48, 8'h49, 8'hB4, 8'hB5, 8'hB6, 8'hB9})
		else $error("unknown frame id");
	AST_TPER: assert property (tick_out |-> timer_period_out >= 16'h03E8)
		else $error("timer period below minimum");
	AST_UTC: assert property (tick_out && utc_sync_out
		|-> 32'h000F4240 % timer_period_out == 32'h0)
		else $error("utc sync on odd period");
	AST_TICK_GAP: assert property (tick_out |=> !tick_out [*8])
		else $error("ticks too close");
	AST_BAUD_PRI: assert property (tick_out
		|-> baud_pri_out inside {[32'h00000960:32'h00989680]})
		else $error("primary rate out of range");
	AST_BAUD_GA: assert property (tick_out
		|-> baud_gpio_out inside {[32'h00000960:32'h0003D090]}
		&& baud_aux_out inside {[32'h00000960:32'h001E8480]})
		else $error("gpio or aux rate out of range");
endmodule
bind prc_interpreter prc_interpreter_chk i_chk (.*);
`default_nettype wire

// >>> test/prc_interpreter_tb_top.sv
// Purpose: self-checking bench of the interpreter
// Assumes: 10 MHz clock, inputs driven on the rising edge
// Notes: timer at 2000 us for the utc check, then 1000 us for the rate check so a tick is 10000 cycles
`timescale 1ns/1ps
`default_nettype none
module prc_interpreter_tb_top;
	// ------
	// bench
	// ------
	logic ref_clk_in = 0, reset_n_in = 0, por_n_in = 0, rx_valid_in = 0;
	logic rx_first_in = 0, rx_last_in = 0, rd_req_in = 0, gim_valid_in = 0;
	logic auto_valid_in = 0, utc_pps_in = 0, tx_ready_in, rj;
	logic [7:0] rx_data_in = 0, rx_id_in = 0, rd_id_in = 0, tx_data_out;
	logic [31:0] gim_angle_in = 0, auto_odo_in = 0, auto_slip_in = 0;
	logic [31:0] auto_velx_in = 0, auto_vely_in = 0, auto_dev_in = 0;
	logic [31:0] baud_pri_out, baud_gpio_out, baud_aux_out, b0, b1, b2;
	logic rx_ready_out, rd_ready_out, tx_valid_out, tx_first_out;
	logic tx_last_out, utc_sync_out, tick_out, reject_out;
	logic [15:0] timer_period_out;
	logic [575:0] align_out, ea;
	logic [7:0] pk[$], ex[$];
	int miscompares = 0, tests_run = 0, i, t;
	prc_interpreter i_dut (.*);
	prc_host_sink i_host (.ref_clk_in(ref_clk_in), .tx_valid_in(tx_valid_out),
		.tx_data_in(tx_data_out), .tx_first_in(tx_first_out),
		.tx_last_in(tx_last_out), .tx_ready_out(tx_ready_in));
	initial forever #50 ref_clk_in = ~ref_clk_in;
	task end_sim;
		if (miscompares == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [575:0] s, input logic [575:0] e);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %0t seen %0h want %0h", $time, s, e);
		end
	endtask
	task bound(input int w, input int m);
		if (w >= m) begin
			miscompares++;
			end_sim;
		end
	endtask
	function void put(input logic [31:0] v, input int n, input bit e);
		for (int k = 0; k < n; k++)
			if (e) ex.push_back(v[8*k+:8]);
			else pk.push_back(v[8*k+:8]);
	endfunction
	task send(input logic [7:0] id);
		int w, k;
		for (k = 0; k < pk.size(); k++) begin
			rx_valid_in <= 1'b1;
			rx_data_in <= pk[k];
			rx_first_in <= k == 0;
			rx_last_in <= k == pk.size() - 1;
			rx_id_in <= id;
			w = 0;
			do begin
				@(negedge ref_clk_in);
				w++;
			end while (rx_ready_out !== 1'b1 && w < 99);
			bound(w, 99);
			@(posedge ref_clk_in);
		end
		rx_valid_in <= 1'b0;
		rx_first_in <= 1'b0;
		rx_last_in <= 1'b0;
		@(posedge ref_clk_in);
		@(negedge ref_clk_in);
		rj = reject_out;
		@(posedge ref_clk_in);
	endtask
	task tmr(input logic [7:0] u, input logic [15:0] p);
		pk = {8'h00, u, p[7:0], p[15:8]};
		send(8'hB4);
	endtask
	task bd(input logic [7:0] m, input logic [31:0] a, g, x);
		pk = {m};
		put(a, 4, 0);
		put(g, 4, 0);
		put(x, 4, 0);
		put(32'h0, 4, 0);
		send(8'hB6);
	endtask
	task per(input logic [7:0] c, id, input logic [31:0] n);
		pk = {8'h00, c, id};
		put(n, 4, 0);
		send(8'hB5);
	endtask
	task rd(input logic [7:0] id);
		int w;
		rd_req_in <= 1'b1;
		rd_id_in <= id;
		w = 0;
		do begin
			@(negedge ref_clk_in);
			w++;
		end while (rd_ready_out !== 1'b1 && w < 99);
		bound(w, 99);
		@(posedge ref_clk_in);
		rd_req_in <= 1'b0;
	endtask
	// permanence byte of a readback is skipped
	task chkf(input int skip);
		int w;
		w = 0;
		while (i_host.q.size() < ex.size() && w < 999) begin
			@(posedge ref_clk_in);
			w++;
		end
		bound(w, 999);
		foreach (ex[k])
			if (k != skip) chk(i_host.q[k], ex[k]);
		chk(i_host.lst[ex.size() - 1], 1'b1);
		i_host.q.delete();
		i_host.lst.delete();
	endtask
	initial begin
		void'($urandom(32'h80807B5F));
		repeat (20) @(posedge ref_clk_in);
		por_n_in <= 1'b1;
		reset_n_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		tmr(8'h01, 16'h07D0);
		chk(timer_period_out, 16'h07D0);
		chk(utc_sync_out, 1'b1);
		// second edge restarts the phase: three sync flops, then 20000 cycles
		utc_pps_in <= 1'b1;
		repeat (20002) @(posedge ref_clk_in);
		@(negedge ref_clk_in) rj = tick_out;
		@(negedge ref_clk_in);
		chk({rj, tick_out}, 2'b01);
		@(posedge ref_clk_in);
		tmr(8'h01, 16'h05DC);
		chk(rj, 1'b1);
		tmr(8'h00, 16'h03E7);
		chk(rj, 1'b1);
		pk = {8'h00, 8'h00, 8'hE8};
		send(8'hB4);
		chk(rj, 1'b1);
		chk(timer_period_out, 16'h07D0);
		tmr(8'h00, 16'h03E8);
		rd(8'hB4);
		ex = {8'hB4, 8'h04, 8'h00, 8'h00, 8'hE8, 8'h03};
		chkf(2);
		b0 = 32'h00000960 + $urandom % 32'h00988D21;
		b1 = 32'h00000960 + $urandom % 32'h0003C731;
		b2 = 32'h00000960 + $urandom % 32'h001E7B21;
		bd(8'h01, b0, b1, b2);
		chk(baud_pri_out, b0);
		chk({baud_gpio_out, baud_aux_out}, {b1, b2});
		bd(8'h00, 32'h00989680, 32'h0003D091, b2);
		chk(rj, 1'b1);
		chk(baud_gpio_out, b1);
		pk = {8'h00};
		for (i = 0; i < 18; i++)
			put($urandom, 4, 0);
		for (i = 0; i < 72; i++)
			ea[8*i+:8] = pk[i+1];
		send(8'hB9);
		chk(align_out, ea);
		gim_angle_in <= $urandom;
		gim_valid_in <= 1'b1;
		@(posedge ref_clk_in);
		gim_valid_in <= 1'b0;
		ex = {8'h48, 8'h08};
		put(gim_angle_in, 4, 1);
		put(32'h0, 4, 1);
		chkf(-1);
		{auto_odo_in, auto_slip_in, auto_velx_in} <= {$urandom, $urandom, $urandom};
		{auto_vely_in, auto_dev_in} <= {$urandom, $urandom};
		auto_valid_in <= 1'b1;
		@(posedge ref_clk_in);
		auto_valid_in <= 1'b0;
		ex = {8'h49, 8'h18};
		put(auto_odo_in, 4, 1);
		put(auto_slip_in, 4, 1);
		put(auto_velx_in, 4, 1);
		put(auto_vely_in, 4, 1);
		put(auto_dev_in, 4, 1);
		put(32'h0, 4, 1);
		chkf(-1);
		per(8'h01, 8'h48, 32'h5);
		per(8'h00, 8'h49, 32'h0);
		per(8'h00, 8'h48, 32'h0);
		rd(8'hB5);
		ex = {8'hB5, 8'h0C, 8'h00, 8'h00, 8'h48};
		put(32'h0, 4, 1);
		ex.push_back(8'h49);
		put(32'h0, 4, 1);
		chkf(2);
		per(8'h01, 8'h49, 32'h0);
		rd(8'hB5);
		ex = {8'hB5, 8'h07, 8'h00, 8'h00, 8'h49};
		put(32'h0, 4, 1);
		chkf(2);
		per(8'h01, 8'h48, 32'h1);
		i_host.ft.delete();
		t = 0;
		while (i_host.ft.size() < 3 && t < 40000) begin
			@(posedge ref_clk_in);
			t++;
		end
		bound(t, 40000);
		t = i_host.ft[2] - i_host.ft[1];
		chk(t inside {[9980:10020]}, 1'b1);
		tmr(8'h00, 16'h07D0);
		reset_n_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		reset_n_in <= 1'b1;
		repeat (3) @(posedge ref_clk_in);
		chk({baud_pri_out, timer_period_out}, {b0, 16'h03E8});
		end_sim;
	end
endmodule
`default_nettype wire
